//--- hdl/dpsp_pkg.sv
// Shared constants and types for one port of the dual-port memory and its host.
// Assumes both ends run on one common 25 MHz clock (40 ns period).
package dpsp_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int ADDR_W = 18;
  localparam int DATA_W = 18;
  localparam int LANE_W = 9;

  // ************************************************************
  // Reset values and fixed locations
  // ************************************************************
  localparam logic [17:0] CNT_RESET = 18'h00000;
  localparam logic [17:0] MASK_RESET = 18'h3FFFF;
  localparam logic [17:0] MAILBOX_ADDR = 18'h3FFFF;
  localparam logic [17:0] BUS_IDLE = 18'h3FFFF;

  // ************************************************************
  // Master clear timing, already in clock cycles
  // ************************************************************
  localparam int MCLR_HOLD_CYC = 5;
  localparam int MCLR_RECOVER_CYC = 5;

  // ************************************************************
  // Host commands and counter operations
  // ************************************************************
  typedef enum logic [2:0] {
    CMD_READ, CMD_WRITE, CMD_LOAD_MASK, CMD_CLEAR_CNT,
    CMD_READBACK_CNT, CMD_READBACK_MASK, CMD_MASTER_CLEAR, CMD_NOP
  } dpsp_cmd_t;

  typedef enum logic [2:0] {
    OP_HOLD, OP_INC, OP_LOAD, OP_READBACK,
    OP_CLEAR, OP_MASK_LOAD, OP_MASK_READBACK, OP_MASK_CLEAR
  } dpsp_op_t;

endpackage

//--- hdl/dpsp_if.sv
// Pin-level carrier between one memory port and its host controller.
// Assumes the address and data buses are pulled high when nobody drives.
`timescale 1ns/1ns
interface dpsp_if;
  import dpsp_pkg::*;

  // ************************************************************
  // Host-driven controls
  // ************************************************************
  logic chip_select_low_active;
  logic chip_select_high_active;
  logic read_not_write;
  logic output_drive_n;
  logic address_load_strobe_n;
  logic counter_advance_n;
  logic counter_or_mask_select;
  logic counter_clear_n;
  logic master_clear_n;
  logic byte_lane0_enable_n;
  logic byte_lane1_enable_n;

  // ************************************************************
  // Two-way buses, one side each
  // ************************************************************
  logic [ADDR_W-1:0] addr_host;
  logic addr_host_oe_n;
  logic [ADDR_W-1:0] addr_dev;
  logic addr_dev_oe_n;
  logic [DATA_W-1:0] dq_host;
  logic dq_host_oe_n;
  logic [DATA_W-1:0] dq_dev;
  logic dq_dev_oe_n;
  logic [ADDR_W-1:0] addr_bus;
  logic [DATA_W-1:0] dq_bus;

  // ************************************************************
  // Device flags
  // ************************************************************
  logic counter_wrap_flag_n;
  logic mailbox_flag_n;

  // Pull-up when both sides release
  assign addr_bus = !addr_host_oe_n ? addr_host : (!addr_dev_oe_n ? addr_dev : BUS_IDLE);
  assign dq_bus = !dq_host_oe_n ? dq_host : (!dq_dev_oe_n ? dq_dev : BUS_IDLE);

  modport device (
    input chip_select_low_active, chip_select_high_active, read_not_write,
    input output_drive_n, address_load_strobe_n, counter_advance_n,
    input counter_or_mask_select, counter_clear_n, master_clear_n,
    input byte_lane0_enable_n, byte_lane1_enable_n, addr_bus, dq_bus,
    output addr_dev, addr_dev_oe_n, dq_dev, dq_dev_oe_n,
    output counter_wrap_flag_n, mailbox_flag_n
  );

  modport host (
    output chip_select_low_active, chip_select_high_active, read_not_write,
    output output_drive_n, address_load_strobe_n, counter_advance_n,
    output counter_or_mask_select, counter_clear_n, master_clear_n,
    output byte_lane0_enable_n, byte_lane1_enable_n,
    output addr_host, addr_host_oe_n, dq_host, dq_host_oe_n,
    input addr_bus, dq_bus, addr_dev_oe_n, counter_wrap_flag_n, mailbox_flag_n
  );
endinterface

//--- hdl/dpsp_device.sv
// One port of a pipelined synchronous dual-port memory: array, burst counter,
// mask register, readback, mailbox and counter-wrap flags.
// Assumes the host runs on the same clock and keeps its own timing duties.
`timescale 1ns/1ns
module dpsp_device #(
  parameter int ADDR_W = dpsp_pkg::ADDR_W,
  parameter int DATA_W = dpsp_pkg::DATA_W
) (
  input wire logic CLK,
  input wire logic RST,
  dpsp_if.device PINS
);
  import dpsp_pkg::*;

  // ************************************************************
  // Counter operation decode
  // ************************************************************
  function automatic dpsp_op_t ctr_decode(input logic cnt_sel, input logic load_n,
                                          input logic adv_n, input logic clr_n);
    dpsp_op_t op;
    op = OP_HOLD;
    if (!clr_n) begin
      op = cnt_sel ? OP_CLEAR : OP_MASK_CLEAR;
    end else begin
      case ({load_n, adv_n})
        2'b00: op = cnt_sel ? OP_LOAD : OP_MASK_LOAD;
        2'b01: op = cnt_sel ? OP_READBACK : OP_MASK_READBACK;
        2'b10: op = cnt_sel ? OP_INC : OP_HOLD;
        default: op = OP_HOLD;
      endcase
    end
    return op;
  endfunction

  logic [ADDR_W-1:0] cnt_reg;
  logic [ADDR_W-1:0] base_reg;
  logic [ADDR_W-1:0] mask_reg;
  logic [ADDR_W-1:0] addr_out_reg;
  logic addr_drive_n_reg;
  logic [DATA_W-1:0] dq_out_reg;
  logic dq_drive_reg;
  logic wrap_flag_n_reg;
  logic mbox_flag_n_reg;
  logic [DATA_W-1:0] mem [0:(2**ADDR_W)-1];

  dpsp_op_t op;
  logic ce_act;
  logic [ADDR_W-1:0] inc_next;
  logic [ADDR_W-1:0] eff_addr;
  logic inc_hits_max;
  logic wr_blocked;
  logic wr_go;
  logic rd_go;
  logic any_lane;
  logic at_mailbox;

  // ************************************************************
  // Sampled controls, all taken at the rising edge
  // ************************************************************
  assign op = ctr_decode(PINS.counter_or_mask_select, PINS.address_load_strobe_n,
                         PINS.counter_advance_n, PINS.counter_clear_n);
  assign ce_act = !PINS.chip_select_low_active && PINS.chip_select_high_active;
  assign any_lane = !PINS.byte_lane0_enable_n || !PINS.byte_lane1_enable_n;

  // Unmasked bits count; at their maximum the loaded address comes back
  always_comb begin
    if ((cnt_reg & mask_reg) == mask_reg) begin
      inc_next = base_reg;
    end else begin
      inc_next = (cnt_reg & ~mask_reg) | (ADDR_W'(cnt_reg + 1'b1) & mask_reg);
    end
  end

  assign inc_hits_max = (op == OP_INC) && ((inc_next & mask_reg) == mask_reg);

  // Access uses the counter value this edge loads (incremented, loaded or cleared); a clear still lets it run
  always_comb begin
    case (op)
      OP_LOAD: eff_addr = PINS.addr_bus;
      OP_CLEAR: eff_addr = CNT_RESET;
      OP_INC: eff_addr = inc_next;
      default: eff_addr = cnt_reg;
    endcase
  end

  assign at_mailbox = (eff_addr == MAILBOX_ADDR);

  // Data still driven with the gate open: the write lane would fight the bus
  assign wr_blocked = dq_drive_reg && !PINS.output_drive_n;
  assign wr_go = ce_act && !PINS.read_not_write && !wr_blocked;
  assign rd_go = ce_act && PINS.read_not_write;

  // ************************************************************
  // Burst counter and mask register
  // ************************************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      cnt_reg <= CNT_RESET;
      base_reg <= CNT_RESET;
      mask_reg <= MASK_RESET;
    end else begin
      cnt_reg <= eff_addr;
      case (op)
        OP_LOAD: base_reg <= PINS.addr_bus;
        OP_CLEAR: base_reg <= CNT_RESET;
        OP_MASK_LOAD: mask_reg <= PINS.addr_bus;
        OP_MASK_CLEAR: mask_reg <= MASK_RESET;
        default: base_reg <= base_reg;
      endcase
    end
  end

  // ************************************************************
  // Memory array
  // ************************************************************
  // No reset on the array; the other port may write the same word and then
  // the stored value is undefined
  always_ff @(posedge CLK) begin
    if (wr_go && !PINS.byte_lane0_enable_n) begin
      mem[eff_addr][LANE_W-1:0] <= PINS.dq_bus[LANE_W-1:0];
    end
    if (wr_go && !PINS.byte_lane1_enable_n) begin
      mem[eff_addr][DATA_W-1:LANE_W] <= PINS.dq_bus[DATA_W-1:LANE_W];
    end
  end

  // Read register; a word written on the last edge is already visible
  always_ff @(posedge CLK) begin
    if (RST) begin
      dq_out_reg <= '0;
    end else if (rd_go) begin
      dq_out_reg <= mem[eff_addr];
    end
  end

  // ************************************************************
  // Output pipeline, cleared at once by master clear
  // ************************************************************
  always_ff @(posedge CLK or negedge PINS.master_clear_n) begin
    if (!PINS.master_clear_n) begin
      dq_drive_reg <= 1'b0;
    end else if (RST) begin
      dq_drive_reg <= 1'b0;
    end else begin
      dq_drive_reg <= rd_go;
    end
  end

  // Hi-Z begins at the edge after deselect, never mid-cycle
  assign PINS.dq_dev = dq_out_reg;
  // Gate acts without the clock, so it is the one combinational term here
  assign PINS.dq_dev_oe_n = !dq_drive_reg || PINS.output_drive_n;

  // ************************************************************
  // Readback on the address lines
  // ************************************************************
  always_ff @(posedge CLK or negedge PINS.master_clear_n) begin
    if (!PINS.master_clear_n) begin
      addr_drive_n_reg <= 1'b1;
    end else if (RST) begin
      addr_drive_n_reg <= 1'b1;
    end else begin
      addr_drive_n_reg <= !((op == OP_READBACK) || (op == OP_MASK_READBACK));
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      addr_out_reg <= '0;
    end else if (op == OP_READBACK) begin
      addr_out_reg <= cnt_reg;
    end else if (op == OP_MASK_READBACK) begin
      addr_out_reg <= mask_reg;
    end
  end

  assign PINS.addr_dev = addr_out_reg;
  assign PINS.addr_dev_oe_n = addr_drive_n_reg;

  // ************************************************************
  // Flags
  // ************************************************************
  always_ff @(posedge CLK or negedge PINS.master_clear_n) begin
    if (!PINS.master_clear_n) begin
      wrap_flag_n_reg <= 1'b1;
    end else if (RST) begin
      wrap_flag_n_reg <= 1'b1;
    end else if (op == OP_INC) begin
      wrap_flag_n_reg <= !inc_hits_max;
    end else if (op != OP_HOLD && op != OP_READBACK && op != OP_MASK_READBACK) begin
      wrap_flag_n_reg <= 1'b1;
    end
  end

  // Set wins over clear; both need a lane enabled
  always_ff @(posedge CLK or negedge PINS.master_clear_n) begin
    if (!PINS.master_clear_n) begin
      mbox_flag_n_reg <= 1'b1;
    end else if (RST) begin
      mbox_flag_n_reg <= 1'b1;
    end else if (wr_go && at_mailbox && any_lane) begin
      mbox_flag_n_reg <= 1'b0;
    end else if (rd_go && at_mailbox && any_lane) begin
      mbox_flag_n_reg <= 1'b1;
    end
  end

  assign PINS.counter_wrap_flag_n = wrap_flag_n_reg;
  assign PINS.mailbox_flag_n = mbox_flag_n_reg;

endmodule

//--- hdl/dpsp_host.sv
// Host controller for one memory port: turns single commands into pin cycles.
// Assumes the memory port shares this clock and samples pins at rising edges.
`timescale 1ns/1ns
module dpsp_host (
  input wire logic CLK,
  input wire logic RST,
  dpsp_if.host PINS,
  input wire logic CMD_VALID,
  input wire dpsp_pkg::dpsp_cmd_t CMD,
  input wire logic [dpsp_pkg::ADDR_W-1:0] CMD_ADDR,
  input wire logic [dpsp_pkg::DATA_W-1:0] CMD_WDATA,
  input wire logic [1:0] CMD_BE_N,
  output logic CMD_READY,
  output logic RSP_VALID,
  output logic [dpsp_pkg::DATA_W-1:0] RSP_DATA
);
  import dpsp_pkg::*;

  typedef enum {S_IDLE, S_ISSUE, S_DATA, S_RELEASE, S_MCLR, S_RECOVER} dpsp_state_t;

  dpsp_state_t state_reg;
  dpsp_cmd_t cmd_reg;
  logic [2:0] wait_reg;
  logic [1:0] be_n_next;

  // Mailbox traffic with no lane enabled would be lost on the flag
  assign be_n_next = (CMD_ADDR == MAILBOX_ADDR && CMD_BE_N == 2'b11) ? 2'b10 : CMD_BE_N;

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg <= S_IDLE;
      cmd_reg <= CMD_NOP;
      wait_reg <= '0;
      CMD_READY <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_DATA <= '0;
    end else begin
      RSP_VALID <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          CMD_READY <= 1'b1;
          if (CMD_VALID && CMD_READY) begin
            cmd_reg <= CMD;
            CMD_READY <= 1'b0;
            wait_reg <= '0;
            state_reg <= (CMD == CMD_MASTER_CLEAR) ? S_MCLR : S_ISSUE;
          end
        end
        S_ISSUE: begin
          if (cmd_reg == CMD_READ || cmd_reg == CMD_READBACK_CNT ||
              cmd_reg == CMD_READBACK_MASK) begin
            state_reg <= S_DATA;
          end else begin
            state_reg <= S_IDLE;
          end
        end
        S_DATA: begin
          RSP_VALID <= 1'b1;
          RSP_DATA <= (cmd_reg == CMD_READ) ? PINS.dq_bus : PINS.addr_bus;
          state_reg <= (cmd_reg == CMD_READ) ? S_IDLE : S_RELEASE;
        end
        S_RELEASE: begin
          if (PINS.addr_dev_oe_n) begin
            state_reg <= S_IDLE;
          end
        end
        S_MCLR: begin
          wait_reg <= 3'(wait_reg + 1'b1);
          if (wait_reg == 3'(MCLR_HOLD_CYC - 1)) begin
            wait_reg <= '0;
            state_reg <= S_RECOVER;
          end
        end
        S_RECOVER: begin
          wait_reg <= 3'(wait_reg + 1'b1);
          if (wait_reg == 3'(MCLR_RECOVER_CYC - 1)) begin
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Pin drive, registered; idle means deselected and released
  // ************************************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      PINS.chip_select_low_active <= 1'b1;
      PINS.read_not_write <= 1'b1;
      PINS.output_drive_n <= 1'b1;
      PINS.address_load_strobe_n <= 1'b1;
      PINS.counter_advance_n <= 1'b1;
      PINS.counter_or_mask_select <= 1'b1;
      PINS.counter_clear_n <= 1'b1;
      PINS.master_clear_n <= 1'b1;
      PINS.byte_lane0_enable_n <= 1'b1;
      PINS.byte_lane1_enable_n <= 1'b1;
      PINS.addr_host <= '0;
      PINS.addr_host_oe_n <= 1'b1;
      PINS.dq_host <= '0;
      PINS.dq_host_oe_n <= 1'b1;
    end else begin
      PINS.chip_select_low_active <= 1'b1;
      PINS.read_not_write <= 1'b1;
      PINS.address_load_strobe_n <= 1'b1;
      PINS.counter_advance_n <= 1'b1;
      PINS.counter_or_mask_select <= 1'b1;
      PINS.counter_clear_n <= 1'b1;
      PINS.addr_host_oe_n <= 1'b1;
      PINS.dq_host_oe_n <= 1'b1;
      PINS.master_clear_n <= !(state_reg == S_IDLE && CMD_VALID && CMD_READY &&
                               CMD == CMD_MASTER_CLEAR) && !(state_reg == S_MCLR &&
                               wait_reg != 3'(MCLR_HOLD_CYC - 1));
      // Drive gate open from the read request cycle through the read data cycle only
      PINS.output_drive_n <= !((state_reg == S_IDLE && CMD_VALID && CMD_READY &&
                                CMD == CMD_READ) ||
                               (state_reg == S_ISSUE && cmd_reg == CMD_READ));
      if (state_reg == S_IDLE && CMD_VALID && CMD_READY) begin
        PINS.addr_host <= CMD_ADDR;
        PINS.dq_host <= CMD_WDATA;
        {PINS.byte_lane1_enable_n, PINS.byte_lane0_enable_n} <= be_n_next;
        case (CMD)
          CMD_READ: begin
            PINS.chip_select_low_active <= 1'b0;
            PINS.address_load_strobe_n <= 1'b0;
            PINS.counter_advance_n <= 1'b0;
            PINS.addr_host_oe_n <= 1'b0;
          end
          CMD_WRITE: begin
            // Gate already closed, so no wasted cycle and no corrupt no-op
            PINS.chip_select_low_active <= 1'b0;
            PINS.read_not_write <= 1'b0;
            PINS.address_load_strobe_n <= 1'b0;
            PINS.counter_advance_n <= 1'b0;
            PINS.addr_host_oe_n <= 1'b0;
            PINS.dq_host_oe_n <= 1'b0;
          end
          CMD_LOAD_MASK: begin
            PINS.address_load_strobe_n <= 1'b0;
            PINS.counter_advance_n <= 1'b0;
            PINS.counter_or_mask_select <= 1'b0;
            PINS.addr_host_oe_n <= 1'b0;
          end
          CMD_CLEAR_CNT: PINS.counter_clear_n <= 1'b0;
          CMD_READBACK_CNT, CMD_READBACK_MASK: begin
            // Address bus left released for the device to answer on
            PINS.address_load_strobe_n <= 1'b0;
            PINS.counter_or_mask_select <= (CMD == CMD_READBACK_CNT);
          end
          // No-op steps the counter once with the chip deselected
          CMD_NOP: PINS.counter_advance_n <= 1'b0;
          default: PINS.address_load_strobe_n <= 1'b1;
        endcase
      end
    end
  end

  assign PINS.chip_select_high_active = 1'b1;

endmodule

//--- tb/dpsp_checker.sv
// Concurrent checks on the pins between one memory port and its host.
// Assumes one shared clock and a synchronous active-high reset for both ends.
`timescale 1ns/1ns
module dpsp_checker (
  input wire logic CLK,
  input wire logic RST,
  input wire logic chip_select_low_active,
  input wire logic chip_select_high_active,
  input wire logic read_not_write,
  input wire logic output_drive_n,
  input wire logic address_load_strobe_n,
  input wire logic counter_advance_n,
  input wire logic master_clear_n,
  input wire logic addr_host_oe_n,
  input wire logic addr_dev_oe_n,
  input wire logic dq_dev_oe_n,
  input wire logic counter_wrap_flag_n,
  input wire logic mailbox_flag_n
);
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (RST);

  logic sel;
  assign sel = !chip_select_low_active && chip_select_high_active;

  // ************************************************************
  // Device side
  // ************************************************************
  a_deselect_hiz: assert property (!sel |=> dq_dev_oe_n)
    else $error("data still driven after deselect");
  a_read_drive: assert property (sel && read_not_write && !address_load_strobe_n
    && !counter_advance_n && master_clear_n |=> output_drive_n || !dq_dev_oe_n)
    else $error("read data not driven one cycle after request");
  a_mclr_idle: assert property (!master_clear_n |-> dq_dev_oe_n && addr_dev_oe_n)
    else $error("outputs driven during master clear");
  a_mclr_flags: assert property (!master_clear_n |-> counter_wrap_flag_n && mailbox_flag_n)
    else $error("flags not cleared by master clear");
  a_readback_drive: assert property (!address_load_strobe_n && counter_advance_n
    && master_clear_n |=> !addr_dev_oe_n)
    else $error("address pins not driven during readback");

  // ************************************************************
  // Host side
  // ************************************************************
  a_host_release: assert property (!address_load_strobe_n && counter_advance_n
    |-> addr_host_oe_n)
    else $error("host drives address during readback request");
  a_addr_no_clash: assert property (!addr_dev_oe_n |-> addr_host_oe_n)
    else $error("both ends drive the address bus");
  a_write_gate: assert property (sel && !read_not_write |-> output_drive_n)
    else $error("write issued with output drive enabled");
  a_mclr_width: assert property ($fell(master_clear_n) |-> !master_clear_n [*5])
    else $error("master clear pulse too short");
  a_mclr_recover: assert property ($rose(master_clear_n) |-> chip_select_low_active [*5])
    else $error("access too soon after master clear");

  c_read: cover property (sel && read_not_write);
  c_write: cover property (sel && !read_not_write);
  c_readback: cover property (!addr_dev_oe_n);
  c_mclr: cover property ($rose(master_clear_n));
  c_wrap: cover property ($fell(counter_wrap_flag_n));
endmodule

//--- tb/test_dual_port_sync_sram_port.sv
// Self-checking bench: host command port drives the memory port through the pins.
// Assumes one 25 MHz clock and the design files under hdl/.
`timescale 1ns/1ns
module test_dual_port_sync_sram_port;
  import dpsp_pkg::*;

`define CHECK_EQ(got, exp, msg) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp); \
  end \
end

  // ************************************************************
  // Clock, reset, instances
  // ************************************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  dpsp_cmd_t cmd = CMD_NOP;
  logic [ADDR_W-1:0] cmd_addr = '0;
  logic [DATA_W-1:0] cmd_wdata = '0;
  logic [1:0] cmd_be_n = 2'b11;
  logic cmd_ready;
  logic rsp_valid;
  logic [DATA_W-1:0] rsp_data;
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [DATA_W-1:0] got;

  always #20 clk = ~clk;

  dpsp_if dpsp_if_i ();
  dpsp_device dpsp_device_i (.CLK(clk), .RST(rst), .PINS(dpsp_if_i));
  dpsp_host dpsp_host_i (.CLK(clk), .RST(rst), .PINS(dpsp_if_i), .CMD_VALID(cmd_valid),
    .CMD(cmd), .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata), .CMD_BE_N(cmd_be_n),
    .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data));
  dpsp_checker dpsp_checker_i (.CLK(clk), .RST(rst),
    .chip_select_low_active(dpsp_if_i.chip_select_low_active),
    .chip_select_high_active(dpsp_if_i.chip_select_high_active),
    .read_not_write(dpsp_if_i.read_not_write),
    .output_drive_n(dpsp_if_i.output_drive_n),
    .address_load_strobe_n(dpsp_if_i.address_load_strobe_n),
    .counter_advance_n(dpsp_if_i.counter_advance_n),
    .master_clear_n(dpsp_if_i.master_clear_n),
    .addr_host_oe_n(dpsp_if_i.addr_host_oe_n),
    .addr_dev_oe_n(dpsp_if_i.addr_dev_oe_n),
    .dq_dev_oe_n(dpsp_if_i.dq_dev_oe_n),
    .counter_wrap_flag_n(dpsp_if_i.counter_wrap_flag_n),
    .mailbox_flag_n(dpsp_if_i.mailbox_flag_n));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic results();
    $display("Comparisons %0d, errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Bounded waits: a stuck host shows as a mismatch, not a hang
  task automatic wait_ready();
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(posedge clk);
      #2;
      n++;
    end
    `CHECK_EQ(cmd_ready, 1'b1, "host not ready")
  endtask

  task automatic issue(input dpsp_cmd_t c, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input logic [1:0] be);
    int n;
    n = 0;
    wait_ready();
    cmd_valid = 1'b1;
    cmd = c;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_be_n = be;
    @(posedge clk);
    #2;
    cmd_valid = 1'b0;
    if (c inside {CMD_READ, CMD_READBACK_CNT, CMD_READBACK_MASK}) begin
      while (rsp_valid !== 1'b1 && n < 20) begin
        @(posedge clk);
        #2;
        n++;
      end
      `CHECK_EQ(rsp_valid, 1'b1, "no response")
      got = rsp_data;
    end
    wait_ready();
    // Next command one cycle after ready returns
    @(posedge clk);
    #2;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_write_read();
    logic [ADDR_W-1:0] at [4] = '{18'h00000, 18'h00001, 18'h2AAAA, 18'h3FFFE};
    logic [DATA_W-1:0] dt [4] = '{18'h15555, 18'h2AAAA, 18'h0F0F0, 18'h3C3C3};
    for (int i = 0; i < 4; i++) begin
      issue(CMD_WRITE, at[i], dt[i], 2'b00);
    end
    for (int i = 3; i >= 0; i--) begin
      issue(CMD_READ, at[i], '0, 2'b11);
      `CHECK_EQ(got, dt[i], "read data")
    end
    // Lane 0 only; write right after a read must still land
    issue(CMD_WRITE, 18'h00001, 18'h3FFFF, 2'b10);
    issue(CMD_READ, 18'h00001, '0, 2'b11);
    `CHECK_EQ(got, 18'h2ABFF, "lane write")
    issue(CMD_READ, 18'h00000, '0, 2'b11);
    `CHECK_EQ(got, 18'h15555, "random address")
  endtask

  task automatic t_readback();
    issue(CMD_READ, 18'h12345, '0, 2'b11);
    issue(CMD_READBACK_CNT, '0, '0, 2'b11);
    `CHECK_EQ(got, 18'h12345, "counter readback")
    issue(CMD_READBACK_MASK, '0, '0, 2'b11);
    `CHECK_EQ(got, MASK_RESET, "mask reset value")
    issue(CMD_LOAD_MASK, 18'h000FF, '0, 2'b11);
    issue(CMD_READBACK_MASK, '0, '0, 2'b11);
    `CHECK_EQ(got, 18'h000FF, "mask readback")
    issue(CMD_LOAD_MASK, MASK_RESET, '0, 2'b11);
    issue(CMD_CLEAR_CNT, '0, '0, 2'b11);
    issue(CMD_READBACK_CNT, '0, '0, 2'b11);
    `CHECK_EQ(got, CNT_RESET, "counter cleared")
  endtask

  // Mask of two bits: the counter runs 100..103 and then comes back to 100
  task automatic t_wrap();
    issue(CMD_LOAD_MASK, 18'h00003, '0, 2'b11);
    issue(CMD_WRITE, 18'h00100, 18'h00000, 2'b00);
    issue(CMD_NOP, '0, '0, 2'b11);
    issue(CMD_NOP, '0, '0, 2'b11);
    `CHECK_EQ(dpsp_if_i.counter_wrap_flag_n, 1'b1, "wrap too early")
    issue(CMD_NOP, '0, '0, 2'b11);
    `CHECK_EQ(dpsp_if_i.counter_wrap_flag_n, 1'b0, "wrap flag")
    issue(CMD_NOP, '0, '0, 2'b11);
    issue(CMD_READBACK_CNT, '0, '0, 2'b11);
    `CHECK_EQ(got, 18'h00100, "retransmit start")
    `CHECK_EQ(dpsp_if_i.counter_wrap_flag_n, 1'b1, "wrap flag after wrap")
    issue(CMD_NOP, '0, '0, 2'b11);
    issue(CMD_READBACK_CNT, '0, '0, 2'b11);
    `CHECK_EQ(got, 18'h00101, "retransmit step")
    issue(CMD_LOAD_MASK, MASK_RESET, '0, 2'b11);
  endtask

  task automatic t_mailbox();
    issue(CMD_WRITE, MAILBOX_ADDR, 18'h00055, 2'b00);
    `CHECK_EQ(dpsp_if_i.mailbox_flag_n, 1'b0, "mailbox set")
    issue(CMD_READ, MAILBOX_ADDR, '0, 2'b11);
    `CHECK_EQ(dpsp_if_i.mailbox_flag_n, 1'b1, "mailbox cleared")
    `CHECK_EQ(got, 18'h00055, "mailbox data")
    issue(CMD_WRITE, MAILBOX_ADDR, 18'h000AA, 2'b00);
    issue(CMD_MASTER_CLEAR, '0, '0, 2'b11);
    `CHECK_EQ(dpsp_if_i.mailbox_flag_n, 1'b1, "mailbox after clear")
    `CHECK_EQ(dpsp_if_i.counter_wrap_flag_n, 1'b1, "wrap after clear")
    `CHECK_EQ(dpsp_if_i.dq_dev_oe_n, 1'b1, "dq idle after clear")
    // Array contents survive master clear
    issue(CMD_READ, 18'h2AAAA, '0, 2'b11);
    `CHECK_EQ(got, 18'h0F0F0, "data kept")
  endtask

  // ************************************************************
  // Main sequence and hang guard
  // ************************************************************
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      $display("ERROR %0t run timed out", $time);
      results();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    #2;
    rst = 1'b0;
    t_write_read();
    t_readback();
    t_wrap();
    t_mailbox();
    results();
  end
endmodule
